/* opmode_pkg.sv */
// Shared constants and types of the operating-mode controller
package opmode_pkg;
   // Mode encodings, Gray along active-sleep-standby-bypass-lineout
   typedef enum logic [2:0] {
      MODE_ACTIVE = 3'h0,
      MODE_SLEEP = 3'h1,
      MODE_STANDBY = 3'h3,
      MODE_BYPASS = 3'h2,
      MODE_LINEOUT = 3'h6
   } mode_e;
   typedef enum logic [1:0] {
      SRC_NONE = 2'h0,
      SRC_I2C = 2'h1,
      SRC_PIN = 2'h2,
      SRC_CLK = 2'h3
   } sleep_src_e;
   typedef enum logic [2:0] {
      CMD_NOP = 3'h0,
      CMD_ACTIVE = 3'h1,
      CMD_BYPASS = 3'h2,
      CMD_LINEOUT = 3'h3,
      CMD_SLEEP = 3'h4,
      CMD_STATUS = 3'h5
   } cmd_e;
   localparam int SAMPLE_W = 16;
   localparam int CHANNELS = 2;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CLK_HZ = 100_000_000;
   localparam int SLEEP_HOLD_MS = 20;
   localparam int SLEEP_HOLD_CYC = SLEEP_HOLD_MS * (CLK_HZ / 1000);
   localparam int EXT_CLK_GAP_NS = 640;
   localparam int EXT_CLK_GAP_CYC = EXT_CLK_GAP_NS / CLK_PERIOD_NS;
   localparam int STANDBY_TMO_MS = 100;
   localparam int STANDBY_TMO_CYC = STANDBY_TMO_MS * (CLK_HZ / 1000);
   localparam logic [2:0] SYNC_RESET = 3'h6;
   localparam logic [15:0] SAMPLE_RESET = 16'h0000;
   localparam logic [7:0] GAP_RESET = 8'h00;
   localparam logic [31:0] CNT_RESET = 32'h0000_0000;
endpackage

/* operating_mode_controller.sv */
// Operating-mode state machine with audio routing and clock watch
`timescale 1ns/1ps
// Overview of operation
// - Five modes: active, bypass, lineout, sleep, standby
// - Active after boot and after pin wake
// - Host command enters active from any mode but sleep
// - Active: noise reduction, processed and raw out
// - Bypass entered only by host command
// - Bypass: inputs passed unchanged to outputs
// - Lineout by command, preamps to line pins
// - Sleep by host command or qualified pin
// - Host-entered sleep exits only on bus clock
// - Pin-entered sleep exits on pin or reset
// - Sleep entered when external clock stops, except in lineout and standby
// - Sleep: no processing, analog off, internal oscillator
// - Standby only after bus-clock wake from sleep
// - Standby waits for active/bypass/lineout command
// - Standby without valid command returns to sleep
// - Pin acts after fall held low 20 ms
// - First dummy command after bus-clock wake is ignored
module operating_mode_controller
   import opmode_pkg::*;
#(
   parameter int SLEEP_HOLD_P = SLEEP_HOLD_CYC,
   parameter int STBY_TMO_P = STANDBY_TMO_CYC
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic boot_done_i,
   input wire logic ext_clk_i,
   input wire logic sleep_pin_i,
   input wire logic scl_i,
   input wire logic cmd_valid_i,
   input wire cmd_e cmd_code_i,
   input wire logic sample_valid_i,
   input wire logic [CHANNELS-1:0][SAMPLE_W-1:0] mic_i,
   input wire logic [SAMPLE_W-1:0] nr_i,
   output mode_e mode_o,
   output sleep_src_e sleep_src_o,
   output logic nr_enable_o,
   output logic analog_en_o,
   output logic int_osc_sel_o,
   output logic line_output_first_o,
   output logic line_output_second_o,
   output logic ext_clk_lost_o,
   output logic status_valid_o,
   output mode_e status_mode_o,
   output logic out_valid_o,
   output logic [SAMPLE_W-1:0] out_ch0_o,
   output logic [SAMPLE_W-1:0] out_ch1_o,
   output logic [CHANNELS-1:0][SAMPLE_W-1:0] stat_peak_o
);

   logic [2:0] meta_q;
   logic [2:0] sync_q;
   logic [2:0] last_q;
   logic ext_edge;
   logic pin_fall;
   logic scl_fall;
   logic [7:0] gap_q;
   logic ext_lost;
   logic hold_run_q;
   logic [31:0] hold_cnt_q;
   logic pin_tog_q;
   logic booted_q;
   logic skip_q;
   logic cmd_ok;
   logic [31:0] tmo_q;
   logic tmo_done;
   mode_e state_q;
   mode_e state_d;
   sleep_src_e src_q;
   sleep_src_e src_d;
   logic stat_clear;

   // Pins and the external clock cross into the local domain
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_q <= SYNC_RESET;
         sync_q <= SYNC_RESET;
         last_q <= SYNC_RESET;
      end else begin
         meta_q <= {scl_i, sleep_pin_i, ext_clk_i};
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign ext_edge = sync_q[0] & ~last_q[0];
   assign pin_fall = ~sync_q[1] & last_q[1];
   assign scl_fall = ~sync_q[2] & last_q[2];

   // External clock watchdog
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         gap_q <= GAP_RESET;
      end else if (ext_edge) begin
         gap_q <= GAP_RESET;
      end else if (gap_q != 8'(EXT_CLK_GAP_CYC)) begin
         gap_q <= gap_q + 8'h01;
      end
   end

   assign ext_lost = (gap_q == 8'(EXT_CLK_GAP_CYC));

   // Sleep pin qualifier: a fall must stay low for the hold time
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hold_run_q <= 1'b0;
         hold_cnt_q <= CNT_RESET;
         pin_tog_q <= 1'b0;
      end else begin
         pin_tog_q <= 1'b0;
         if (pin_fall) begin
            hold_run_q <= 1'b1;
            hold_cnt_q <= CNT_RESET;
         end else if (hold_run_q && sync_q[1]) begin
            hold_run_q <= 1'b0;
         end else if (hold_run_q) begin
            if (hold_cnt_q == 32'(SLEEP_HOLD_P - 1)) begin
               hold_run_q <= 1'b0;
               pin_tog_q <= 1'b1;
            end else begin
               hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         booted_q <= 1'b0;
      end else if (boot_done_i) begin
         booted_q <= 1'b1;
      end
   end

   // The command that wakes the bus is consumed without effect
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         skip_q <= 1'b0;
      end else if (state_q == MODE_SLEEP && state_d == MODE_STANDBY) begin
         skip_q <= 1'b1;
      end else if (cmd_valid_i || state_q != MODE_STANDBY) begin
         skip_q <= 1'b0;
      end
   end

   assign cmd_ok = cmd_valid_i & ~skip_q & booted_q & (state_q != MODE_SLEEP);

   // Standby timeout
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tmo_q <= CNT_RESET;
      end else if (state_q != MODE_STANDBY || cmd_ok) begin
         tmo_q <= CNT_RESET;
      end else if (!tmo_done) begin
         tmo_q <= tmo_q + 32'h0000_0001;
      end
   end

   assign tmo_done = (tmo_q == 32'(STBY_TMO_P - 1));

   always_comb begin
      state_d = state_q;
      src_d = src_q;
      if (booted_q) begin
         case (state_q)
            MODE_SLEEP: begin
               case (src_q)
                  SRC_I2C: begin
                     if (scl_fall) begin
                        state_d = MODE_STANDBY;
                     end
                  end
                  SRC_PIN: begin
                     if (pin_tog_q) begin
                        state_d = MODE_ACTIVE;
                     end
                  end
                  default: begin
                     if (!ext_lost) begin
                        state_d = MODE_ACTIVE;
                     end
                  end
               endcase
               if (state_d != MODE_SLEEP) begin
                  src_d = SRC_NONE;
               end
            end
            MODE_STANDBY: begin
               if (pin_tog_q) begin
                  state_d = MODE_SLEEP;
                  src_d = SRC_PIN;
               end else if (cmd_ok && cmd_code_i == CMD_ACTIVE) begin
                  state_d = MODE_ACTIVE;
               end else if (cmd_ok && cmd_code_i == CMD_BYPASS) begin
                  state_d = MODE_BYPASS;
               end else if (cmd_ok && cmd_code_i == CMD_LINEOUT) begin
                  state_d = MODE_LINEOUT;
               end else if ((cmd_ok && cmd_code_i == CMD_SLEEP) || tmo_done) begin
                  state_d = MODE_SLEEP;
                  src_d = SRC_I2C;
               end
            end
            default: begin
               if (pin_tog_q) begin
                  state_d = MODE_SLEEP;
                  src_d = SRC_PIN;
               end else if (cmd_ok && cmd_code_i == CMD_ACTIVE) begin
                  state_d = MODE_ACTIVE;
               end else if (cmd_ok && cmd_code_i == CMD_BYPASS) begin
                  state_d = MODE_BYPASS;
               end else if (cmd_ok && cmd_code_i == CMD_LINEOUT) begin
                  state_d = MODE_LINEOUT;
               end else if (cmd_ok && cmd_code_i == CMD_SLEEP) begin
                  state_d = MODE_SLEEP;
                  src_d = SRC_I2C;
               end else if (ext_lost && state_q != MODE_LINEOUT) begin
                  state_d = MODE_SLEEP;
                  src_d = SRC_CLK;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= MODE_ACTIVE;
         src_q <= SRC_NONE;
      end else begin
         state_q <= state_d;
         src_q <= src_d;
      end
   end

   // Status reply to the host poll
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         status_valid_o <= 1'b0;
         status_mode_o <= MODE_ACTIVE;
      end else begin
         status_valid_o <= cmd_ok && cmd_code_i == CMD_STATUS;
         if (cmd_ok && cmd_code_i == CMD_STATUS) begin
            status_mode_o <= state_q;
         end
      end
   end

   // Audio routing
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         out_valid_o <= 1'b0;
         out_ch0_o <= SAMPLE_RESET;
         out_ch1_o <= SAMPLE_RESET;
      end else begin
         out_valid_o <= 1'b0;
         if (sample_valid_i && booted_q) begin
            case (state_q)
               MODE_ACTIVE: begin
                  out_valid_o <= 1'b1;
                  out_ch0_o <= nr_i;
                  out_ch1_o <= mic_i[0];
               end
               MODE_BYPASS: begin
                  out_valid_o <= 1'b1;
                  out_ch0_o <= mic_i[0];
                  out_ch1_o <= mic_i[1];
               end
               default: begin
                  out_ch0_o <= SAMPLE_RESET;
                  out_ch1_o <= SAMPLE_RESET;
               end
            endcase
         end
      end
   end

   assign stat_clear = (state_q != MODE_BYPASS) && (state_d == MODE_BYPASS);

   // Peak magnitude per input while bypassed
   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_stat
      logic [SAMPLE_W-1:0] mag;
      assign mag = mic_i[ch][SAMPLE_W-1] ? SAMPLE_W'(-mic_i[ch]) : mic_i[ch];
      always_ff @(posedge clk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            stat_peak_o[ch] <= SAMPLE_RESET;
         end else if (stat_clear) begin
            stat_peak_o[ch] <= SAMPLE_RESET;
         end else if (state_q == MODE_BYPASS && sample_valid_i) begin
            if (mag > stat_peak_o[ch]) begin
               stat_peak_o[ch] <= mag;
            end
         end
      end
   end

   assign mode_o = state_q;
   assign sleep_src_o = src_q;
   assign ext_clk_lost_o = ext_lost;
   assign nr_enable_o = booted_q && state_q == MODE_ACTIVE;
   assign analog_en_o = state_q != MODE_SLEEP;
   // Internal oscillator wherever the external clock may be stopped
   assign int_osc_sel_o = state_q == MODE_SLEEP || state_q == MODE_LINEOUT
      || state_q == MODE_STANDBY;
   assign line_output_first_o = state_q == MODE_LINEOUT;
   assign line_output_second_o = state_q == MODE_LINEOUT;

endmodule

/* opmode_checker.sv */
// Assertion checker for the operating-mode controller
`timescale 1ns/1ps
module opmode_checker
   import opmode_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic scl_i,
   input wire logic cmd_valid_i,
   input wire cmd_e cmd_code_i,
   input wire logic sample_valid_i,
   input wire logic [CHANNELS-1:0][SAMPLE_W-1:0] mic_i,
   input wire logic [SAMPLE_W-1:0] nr_i,
   input wire mode_e mode_o,
   input wire sleep_src_e sleep_src_o,
   input wire logic nr_enable_o,
   input wire logic analog_en_o,
   input wire logic int_osc_sel_o,
   input wire logic line_output_first_o,
   input wire logic out_valid_o,
   input wire logic [SAMPLE_W-1:0] out_ch0_o,
   input wire logic [SAMPLE_W-1:0] out_ch1_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_host_sleep;
      mode_o == MODE_SLEEP && sleep_src_o == SRC_I2C;
   endsequence
   sequence s_bus_fall;
      $fell(scl_i);
   endsequence
   property p_wake;
      s_host_sleep ##1 s_bus_fall |-> ##[1:5] mode_o == MODE_STANDBY;
   endproperty
   property p_analog;
      analog_en_o == (mode_o != MODE_SLEEP);
   endproperty
   property p_osc;
      int_osc_sel_o == (mode_o inside {MODE_SLEEP, MODE_STANDBY, MODE_LINEOUT});
   endproperty
   property p_line;
      line_output_first_o == (mode_o == MODE_LINEOUT);
   endproperty
   property p_byp_cmd;
      $rose(mode_o == MODE_BYPASS) |-> $past(cmd_valid_i && cmd_code_i == CMD_BYPASS);
   endproperty
   property p_lo_cmd;
      $rose(mode_o == MODE_LINEOUT) |-> $past(cmd_valid_i && cmd_code_i == CMD_LINEOUT);
   endproperty
   property p_stby_src;
      $rose(mode_o == MODE_STANDBY) |-> $past(mode_o) == MODE_SLEEP;
   endproperty
   property p_byp_data;
      sample_valid_i && mode_o == MODE_BYPASS |=> out_valid_o
         && out_ch0_o == $past(mic_i[0]) && out_ch1_o == $past(mic_i[1]);
   endproperty
   property p_act_data;
      sample_valid_i && mode_o == MODE_ACTIVE && nr_enable_o |=> out_valid_o
         && out_ch0_o == $past(nr_i) && out_ch1_o == $past(mic_i[0]);
   endproperty
   property p_sleep_out;
      sample_valid_i && mode_o == MODE_SLEEP |=> !out_valid_o;
   endproperty
   a_wake: assert property (p_wake) else $error("no standby after bus wake");
   a_analog: assert property (p_analog) else $error("analog enable wrong");
   a_osc: assert property (p_osc) else $error("clock source select wrong");
   a_line: assert property (p_line) else $error("line output wrong");
   a_byp_cmd: assert property (p_byp_cmd) else $error("bypass without command");
   a_lo_cmd: assert property (p_lo_cmd) else $error("lineout without command");
   a_stby_src: assert property (p_stby_src) else $error("standby not from sleep");
   a_byp_data: assert property (p_byp_data) else $error("bypass data wrong");
   a_act_data: assert property (p_act_data) else $error("active data wrong");
   a_sleep_out: assert property (p_sleep_out) else $error("output in sleep");
endmodule
bind operating_mode_controller opmode_checker chk (.*);

/* host_model.sv */
// Host model: command strobes, bus clock line and sleep pin
`timescale 1ns/1ps
module host_model
   import opmode_pkg::*;
(
   input wire logic clk_i,
   output logic scl_o,
   output logic pin_o,
   output logic cmd_valid_o,
   output cmd_e cmd_code_o
);
   initial begin
      scl_o = 1'b1;
      pin_o = 1'b1;
      cmd_valid_o = 1'b0;
      cmd_code_o = CMD_NOP;
   end
   task automatic send(input cmd_e c);
      @(posedge clk_i) #1;
      cmd_valid_o = 1'b1;
      cmd_code_o = c;
      @(posedge clk_i) #1;
      cmd_valid_o = 1'b0;
   endtask
   task automatic pin_low(input int n);
      @(posedge clk_i) #1;
      pin_o = 1'b0;
      repeat (n) @(posedge clk_i);
      #1 pin_o = 1'b1;
   endtask
   task automatic bus_wake();
      @(posedge clk_i) #1;
      scl_o = 1'b0;
      repeat (4) @(posedge clk_i);
      #1 scl_o = 1'b1;
   endtask
endmodule

/* tb_operating_mode_controller.sv */
// Self-checking bench for the operating-mode controller
`timescale 1ns/1ps
module tb_operating_mode_controller
   import opmode_pkg::*;
;
   typedef struct packed {cmd_e c; mode_e m;} row_s;
   row_s rows[7] = '{'{CMD_BYPASS, MODE_BYPASS}, '{CMD_LINEOUT, MODE_LINEOUT},
      '{CMD_ACTIVE, MODE_ACTIVE}, '{CMD_NOP, MODE_ACTIVE}, '{CMD_LINEOUT, MODE_LINEOUT},
      '{CMD_BYPASS, MODE_BYPASS}, '{CMD_ACTIVE, MODE_ACTIVE}};
   logic clk_i = 0, nrst_i, boot_done_i, ext_clk_i, ext_run = 1;
   logic sample_valid_i, scl_i, sleep_pin_i, cmd_valid_i;
   logic [CHANNELS-1:0][SAMPLE_W-1:0] mic_i, stat_peak_o;
   logic [SAMPLE_W-1:0] nr_i, out_ch0_o, out_ch1_o;
   logic nr_enable_o, analog_en_o, int_osc_sel_o, line_output_first_o;
   logic line_output_second_o, ext_clk_lost_o, status_valid_o, out_valid_o;
   cmd_e cmd_code_i;
   mode_e mode_o, status_mode_o;
   sleep_src_e sleep_src_o;
   int n_mismatch = 0, comparisons = 0;
   operating_mode_controller #(.SLEEP_HOLD_P(50), .STBY_TMO_P(200)) dut (.*);
   host_model host (.clk_i(clk_i), .scl_o(scl_i), .pin_o(sleep_pin_i),
      .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i));
   always #5 clk_i = ~clk_i;
   initial begin
      ext_clk_i = 1'b0;
      #3.3;
      forever #80 if (ext_run) ext_clk_i = ~ext_clk_i;
   end
   task automatic check(input string what, input logic [15:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic samp(input logic [15:0] a, b, c);
      @(posedge clk_i) #1;
      sample_valid_i = 1'b1;
      mic_i = {b, a};
      nr_i = c;
      @(posedge clk_i) #1;
      sample_valid_i = 1'b0;
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #200_000;
      n_mismatch++;
      wrap_up();
   end
   initial begin
      nrst_i = 1'b0;
      boot_done_i = 1'b0;
      sample_valid_i = 1'b0;
      mic_i = '0;
      nr_i = '0;
      cyc(16);
      check("mode", mode_o, MODE_ACTIVE);
      nrst_i = 1'b1;
      cyc(4);
      check("nr_en", nr_enable_o, 1'b0);
      boot_done_i = 1'b1;
      cyc(4);
      check("nr_en", nr_enable_o, 1'b1);
      $display("reset test done");
      foreach (rows[i]) begin
         host.send(rows[i].c);
         check("mode", mode_o, rows[i].m);
         check("line", line_output_second_o, rows[i].m == MODE_LINEOUT);
      end
      $display("table test done");
      samp(16'h1234, 16'h5678, 16'h9abc);
      check("ch0", out_ch0_o, 16'h9abc);
      check("ch1", out_ch1_o, 16'h1234);
      host.send(CMD_BYPASS);
      samp(16'hfff0, 16'h0020, 16'h0000);
      check("ch0", out_ch0_o, 16'hfff0);
      cyc(1);
      check("peak0", stat_peak_o[0], 16'h0010);
      check("peak1", stat_peak_o[1], 16'h0020);
      host.send(CMD_ACTIVE);
      $display("audio test done");
      host.send(CMD_SLEEP);
      check("src", sleep_src_o, SRC_I2C);
      samp(16'h0001, 16'h0002, 16'h0003);
      check("valid", out_valid_o, 1'b0);
      host.pin_low(60);
      host.send(CMD_ACTIVE);
      check("mode", mode_o, MODE_SLEEP);
      host.bus_wake();
      cyc(2);
      check("mode", mode_o, MODE_STANDBY);
      host.send(CMD_ACTIVE);
      check("mode", mode_o, MODE_STANDBY);
      host.send(CMD_STATUS);
      check("stat_v", status_valid_o, 1'b1);
      check("stat_m", status_mode_o, MODE_STANDBY);
      cyc(220);
      check("mode", mode_o, MODE_SLEEP);
      host.bus_wake();
      cyc(2);
      host.send(CMD_NOP);
      host.send(CMD_ACTIVE);
      check("mode", mode_o, MODE_ACTIVE);
      $display("host sleep test done");
      host.pin_low(20);
      cyc(5);
      check("mode", mode_o, MODE_ACTIVE);
      host.pin_low(60);
      check("src", sleep_src_o, SRC_PIN);
      host.bus_wake();
      cyc(5);
      check("mode", mode_o, MODE_SLEEP);
      host.pin_low(60);
      check("mode", mode_o, MODE_ACTIVE);
      $display("pin sleep test done");
      ext_run = 1'b0;
      cyc(90);
      check("lost", ext_clk_lost_o, 1'b1);
      check("src", sleep_src_o, SRC_CLK);
      ext_run = 1'b1;
      cyc(40);
      check("mode", mode_o, MODE_ACTIVE);
      $display("clock loss test done");
      wrap_up();
   end
endmodule
